// ### rtl/cbg_defines.vh
// cbg_defines.vh: constants for the cpu bus glue block
// assumes: included by bare name from rtl files, no other header needed
`ifndef CBG_DEFINES_VH
`define CBG_DEFINES_VH

// cycle types from the cpu status lines {cs2, cs1}
`define CBG_CYC_READ      2'b00
`define CBG_CYC_WRITE     2'b01
`define CBG_CYC_IACK      2'b10
`define CBG_CYC_NONE      2'b11

// interrupt sources, index into the request vector
`define CBG_IRQ_N         4
`define CBG_IRQ_SER_RX    0
`define CBG_IRQ_SER_TX    1
`define CBG_IRQ_NET_PRI   2
`define CBG_IRQ_NET_SEC   3

// vector address codes driven during acknowledge
`define CBG_VEC_SER_RX    3'h4
`define CBG_VEC_SER_TX    3'h5
`define CBG_VEC_NET_PRI   3'h2
`define CBG_VEC_NET_SEC   3'h3
`define CBG_VEC_NONE      3'h0

// memory segment select: upper address bits pick a strobe
`define CBG_SEG_MSB       25
`define CBG_SEG_LSB       24

// data setup time before cycle-done, ns, and cycles at 8 ns
`define CBG_SETUP_NS      16
`define CBG_CLK_NS        8
`define CBG_SETUP_CYC     ((`CBG_SETUP_NS + `CBG_CLK_NS - 1) / `CBG_CLK_NS)

// reset value of strobes (inactive, active low)
`define CBG_CAS_IDLE      4'hf

`endif

// ### rtl/cbg_glue.v
// cbg_glue.v: top of the cpu bus glue block
// assumes: cpu strobes and requests arrive asynchronously; system side
// answers a read with sys_rd_data and sys_ack on sys_clk
`timescale 1ns/1ps
`include "cbg_defines.vh"

module cbg_glue (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        cpu_as_n,
    input  wire        cpu_ds_n,
    input  wire [1:0]  cpu_cycle_type,
    input  wire [31:0] bus_addr_data_in,
    output reg  [31:0] bus_data_out,
    output reg         bus_data_oe_n,
    output reg         cpu_ready_n,
    output reg         cpu_bus_isolate,
    output reg         cpu_bus_direction,
    output reg         sys_req,
    output reg         sys_write,
    output reg  [31:0] sys_addr,
    output reg  [31:0] sys_wr_data,
    input  wire        sys_ack,
    input  wire [31:0] sys_rd_data,
    output reg         col_strobe_3,
    output reg         col_strobe_2,
    output reg         col_strobe_1,
    output reg         col_strobe_0,
    output reg  [3:0]  vram_col_strobe,
    output reg  [11:0] opt_col_strobe,
    input  wire        serial_rx_irq,
    input  wire        serial_tx_irq,
    input  wire        net_irq_primary,
    input  wire        net_irq_secondary,
    output reg         cpu_irq_request,
    output reg         vector_addr_bit2,
    output reg         vector_addr_bit1,
    output reg         vector_addr_bit0
);

////////////////////////////////////////////////////////////////////////////
// reset release and input synchronisers

localparam [2:0] ST_IDLE  = 3'd0;
localparam [2:0] ST_ACCESS = 3'd1;
localparam [2:0] ST_SETUP = 3'd2;
localparam [2:0] ST_DONE  = 3'd3;
localparam [2:0] ST_WAITEND = 3'd4;
localparam integer SETUP_CYC_I = `CBG_SETUP_CYC;
localparam [1:0] SETUP_CYC = SETUP_CYC_I[1:0];

reg  [1:0]  rst_ff;
wire        rst_sync_n;
reg  [1:0]  as_ff;
reg  [1:0]  ds_ff;
reg  [3:0]  cyc_ff;
reg  [2:0]  state_ff;
reg  [2:0]  nxt_state;
reg  [1:0]  cyc_type_ff;
reg  [1:0]  cnt_ff;
reg  [3:0]  seg_ff;
reg  [31:0] bus_s1_ff;
reg  [31:0] bus_s2_ff;
reg  [31:0] addr_lat_ff;
wire        as_act;
wire        ds_act;
wire        irq_any;
wire [2:0]  irq_vec;

assign rst_sync_n = rst_ff[1];
assign as_act     = ~as_ff[1];
assign ds_act     = ~ds_ff[1];

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
        rst_ff <= 2'b00;
    else
        rst_ff <= {rst_ff[0], 1'b1};
end

always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        as_ff  <= 2'b11;
        ds_ff  <= 2'b11;
        cyc_ff <= 4'hf;
        bus_s1_ff   <= 32'h00000000;
        bus_s2_ff   <= 32'h00000000;
        addr_lat_ff <= 32'h00000000;
    end else if (clk_en) begin
        as_ff  <= {as_ff[0], cpu_as_n};
        ds_ff  <= {ds_ff[0], cpu_ds_n};
        cyc_ff <= {cyc_ff[1:0], cpu_cycle_type};
        bus_s1_ff <= bus_addr_data_in;
        bus_s2_ff <= bus_s1_ff;
        // address stands on the shared bus until the data strobe
        if (!ds_act)
            addr_lat_ff <= bus_s2_ff;
    end
end

// one-hot strobe for the segment addressed
function [3:0] seg_decode;
    input [31:0] addr;
    begin
        seg_decode = 4'h1 << addr[`CBG_SEG_MSB:`CBG_SEG_LSB];
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// interrupt collection

cbg_irq_collect u_irq (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .clk_en     (clk_en),
    .irq_raw    ({net_irq_secondary, net_irq_primary,
                  serial_tx_irq, serial_rx_irq}),
    .irq_any    (irq_any),
    .irq_vec    (irq_vec)
);

////////////////////////////////////////////////////////////////////////////
// cycle state machine

always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_IDLE:
            if (as_act && ds_act && cyc_ff[3:2] != `CBG_CYC_NONE)
                nxt_state = (cyc_ff[3:2] == `CBG_CYC_IACK) ? ST_SETUP
                                                            : ST_ACCESS;
        ST_ACCESS:
            if (sys_ack)
                nxt_state = ST_SETUP;
        ST_SETUP:
            if (cnt_ff == SETUP_CYC)
                nxt_state = ST_DONE;
        ST_DONE:
            if (!ds_act)
                nxt_state = ST_WAITEND;
        ST_WAITEND:
            if (!as_act)
                nxt_state = ST_IDLE;
        default:
            nxt_state = ST_IDLE;
    endcase
end

always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        state_ff          <= ST_IDLE;
        cyc_type_ff       <= `CBG_CYC_NONE;
        cnt_ff            <= 2'd0;
        seg_ff            <= 4'h0;
        cpu_ready_n       <= 1'b1;
        cpu_bus_isolate   <= 1'b1;
        cpu_bus_direction <= 1'b0;
        bus_data_out      <= 32'h00000000;
        bus_data_oe_n     <= 1'b1;
        sys_req           <= 1'b0;
        sys_write         <= 1'b0;
        sys_addr          <= 32'h00000000;
        sys_wr_data       <= 32'h00000000;
        col_strobe_3      <= 1'b1;
        col_strobe_2      <= 1'b1;
        col_strobe_1      <= 1'b1;
        col_strobe_0      <= 1'b1;
        vram_col_strobe   <= 4'hf;
        opt_col_strobe    <= 12'hfff;
        cpu_irq_request   <= 1'b0;
        vector_addr_bit2  <= 1'b0;
        vector_addr_bit1  <= 1'b0;
        vector_addr_bit0  <= 1'b0;
    end else if (clk_en) begin
        state_ff        <= nxt_state;
        cpu_irq_request <= irq_any;
        case (state_ff)
            ST_IDLE: begin
                cnt_ff      <= 2'd0;
                cpu_ready_n <= 1'b1;
                if (nxt_state != ST_IDLE) begin
                    cyc_type_ff <= cyc_ff[3:2];
                    sys_addr    <= addr_lat_ff;
                    seg_ff      <= seg_decode(addr_lat_ff);
                    cpu_bus_isolate   <= 1'b0;
                    cpu_bus_direction <=
                        (cyc_ff[3:2] == `CBG_CYC_WRITE);
                    if (cyc_ff[3:2] == `CBG_CYC_WRITE)
                        sys_wr_data <= bus_s2_ff;
                    if (cyc_ff[3:2] == `CBG_CYC_IACK) begin
                        {vector_addr_bit2, vector_addr_bit1,
                         vector_addr_bit0} <= irq_vec;
                        bus_data_out  <= {29'h0, irq_vec};
                        bus_data_oe_n <= 1'b0;
                    end else begin
                        sys_req   <= 1'b1;
                        sys_write <= (cyc_ff[3:2] == `CBG_CYC_WRITE);
                    end
                end
            end
            ST_ACCESS: begin
                {col_strobe_3, col_strobe_2, col_strobe_1,
                 col_strobe_0} <= ~seg_ff;
                vram_col_strobe <= {2'b11, ~seg_ff[1:0]};
                opt_col_strobe  <= {3{~seg_ff}};
                if (sys_ack) begin
                    sys_req <= 1'b0;
                    if (cyc_type_ff == `CBG_CYC_READ) begin
                        bus_data_out  <= sys_rd_data;
                        bus_data_oe_n <= 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                cnt_ff <= cnt_ff + 2'd1;
                if (nxt_state == ST_DONE)
                    cpu_ready_n <= 1'b0;
            end
            ST_DONE: begin
                if (nxt_state == ST_WAITEND)
                    cpu_ready_n <= 1'b1;
            end
            ST_WAITEND: begin
                {col_strobe_3, col_strobe_2, col_strobe_1,
                 col_strobe_0} <= `CBG_CAS_IDLE;
                vram_col_strobe   <= 4'hf;
                opt_col_strobe    <= 12'hfff;
                bus_data_oe_n     <= 1'b1;
                cpu_bus_direction <= 1'b0;
                if (nxt_state == ST_IDLE) begin
                    cpu_bus_isolate  <= 1'b1;
                    vector_addr_bit2 <= 1'b0;
                    vector_addr_bit1 <= 1'b0;
                    vector_addr_bit0 <= 1'b0;
                end
            end
            default: begin
                cpu_ready_n <= 1'b1;
            end
        endcase
    end
end

endmodule // cbg_glue

// ### rtl/cbg_irq_collect.v
// cbg_irq_collect.v: synchronises and prioritises interrupt request levels
// assumes: request lines are asynchronous levels, held until serviced
`timescale 1ns/1ps
`include "cbg_defines.vh"

module cbg_irq_collect (
    input  wire                   sys_clk,
    input  wire                   rst_sync_n,
    input  wire                   clk_en,
    input  wire [`CBG_IRQ_N-1:0]  irq_raw,
    output wire                   irq_any,
    output wire [2:0]             irq_vec
);

reg  [`CBG_IRQ_N-1:0] sync1_ff;
reg  [`CBG_IRQ_N-1:0] sync2_ff;

// encode highest priority pending source
function [2:0] vec_of;
    input [`CBG_IRQ_N-1:0] req;
    begin
        if (req[`CBG_IRQ_NET_PRI])
            vec_of = `CBG_VEC_NET_PRI;
        else if (req[`CBG_IRQ_NET_SEC])
            vec_of = `CBG_VEC_NET_SEC;
        else if (req[`CBG_IRQ_SER_RX])
            vec_of = `CBG_VEC_SER_RX;
        else if (req[`CBG_IRQ_SER_TX])
            vec_of = `CBG_VEC_SER_TX;
        else
            vec_of = `CBG_VEC_NONE;
    end
endfunction

// two-stage level synchroniser, pending while source holds it
genvar gi;
generate
    for (gi = 0; gi < `CBG_IRQ_N; gi = gi + 1) begin : g_sync
        always @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                sync1_ff[gi] <= 1'b0;
                sync2_ff[gi] <= 1'b0;
            end else if (clk_en) begin
                sync1_ff[gi] <= irq_raw[gi];
                sync2_ff[gi] <= sync1_ff[gi];
            end
        end
    end
endgenerate

assign irq_any = |sync2_ff;
assign irq_vec = vec_of(sync2_ff);

endmodule // cbg_irq_collect

// ### verification/cbg_cpu_model.sv
// cbg_cpu_model.sv: cpu end of the local bus, one cycle per call
// assumes: shares sys_clk with the glue, drives just after rising edges
`timescale 1ns/1ps
`include "cbg_defines.vh"

module cbg_cpu_model (
    input wire        sys_clk,
    input wire        cpu_ready_n,
    input wire [31:0] bus_data_out,
    output reg        cpu_as_n = 1'b1,
    output reg        cpu_ds_n = 1'b1,
    output reg [1:0]  cpu_cycle_type = 2'b11,
    output reg [31:0] bus_addr_data_in = 32'h0
);
    task run_cycle(input [1:0] typ, input [31:0] ad, input [31:0] wd,
                   input integer hold, output [31:0] rd, output ok);
        integer n;
        begin
            ok = 1'b0;
            cpu_cycle_type <= typ;
            bus_addr_data_in <= ad;
            cpu_as_n <= 1'b0;
            @(posedge sys_clk);
            if (typ == `CBG_CYC_WRITE)
                bus_addr_data_in <= wd;
            cpu_ds_n <= 1'b0;
            for (n = 0; n < 40 && !ok; n = n + 1) begin
                @(posedge sys_clk);
                ok = (cpu_ready_n === 1'b0);
            end
            rd = bus_data_out;
            repeat (hold) @(posedge sys_clk);
            cpu_ds_n <= 1'b1;
            bus_addr_data_in <= ~bus_addr_data_in;
            for (n = 0; n < 8 && cpu_ready_n !== 1'b1; n = n + 1)
                @(posedge sys_clk);
            cpu_as_n <= 1'b1;
            cpu_cycle_type <= `CBG_CYC_NONE;
            @(posedge sys_clk);
        end
    endtask
endmodule // cbg_cpu_model

// ### verification/cbg_glue_sva.sv
// cbg_glue_sva.sv: port checks for the cpu bus glue top
// assumes: bound to cbg_glue, clk_en held high
`timescale 1ns/1ps

module cbg_glue_sva (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        cpu_ds_n,
    input wire        cpu_ready_n,
    input wire        bus_data_oe_n,
    input wire        cpu_bus_isolate,
    input wire        cpu_bus_direction,
    input wire        sys_req,
    input wire        sys_write,
    input wire        col_strobe_3,
    input wire        col_strobe_2,
    input wire        col_strobe_1,
    input wire        col_strobe_0,
    input wire [3:0]  vram_col_strobe,
    input wire [11:0] opt_col_strobe,
    input wire        serial_rx_irq,
    input wire        serial_tx_irq,
    input wire        net_irq_primary,
    input wire        net_irq_secondary,
    input wire        cpu_irq_request
);
    wire [3:0] cas = {col_strobe_3, col_strobe_2, col_strobe_1, col_strobe_0};
    wire       any = serial_rx_irq | serial_tx_irq | net_irq_primary |
                     net_irq_secondary;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    data_first_a: assert property (
        $fell(cpu_ready_n) && !cpu_bus_direction |-> !$past(bus_data_oe_n))
        else $error("read data late");
    write_done_a: assert property (
        $fell(cpu_ready_n) && cpu_bus_direction |-> !sys_req && bus_data_oe_n)
        else $error("write done early");
    done_release_a: assert property (
        $rose(cpu_ds_n) |-> ##[1:4] cpu_ready_n) else $error("done stuck");
    isolate_done_a: assert property (
        !cpu_ready_n |-> !cpu_bus_isolate) else $error("done while isolated");
    dir_match_a: assert property (
        sys_req |-> cpu_bus_direction == sys_write) else $error("direction");
    one_segment_a: assert property (
        $countones(~cas) <= 1) else $error("two strobes");
    vram_share_a: assert property (
        vram_col_strobe == {2'b11, cas[1:0]}) else $error("vram strobe");
    opt_ports_a: assert property (
        opt_col_strobe == {3{cas}}) else $error("option strobe");
    irq_on_a: assert property (
        any [*8] |-> cpu_irq_request) else $error("irq missing");
    irq_off_a: assert property (
        !any [*8] |-> !cpu_irq_request) else $error("irq stuck");
endmodule // cbg_glue_sva

bind cbg_glue cbg_glue_sva chk (.*);

// ### verification/testbench.sv
// testbench.sv: cpu cycles, system answers and interrupt levels
// assumes: cbg_glue top, cbg_cpu_model partner, clk_en tied high
`timescale 1ns/1ps
`include "cbg_defines.vh"

module testbench;
    reg          sys_clk, rst_n = 1'b0, sys_ack = 1'b0, ok, ew_on = 1'b0;
    reg          serial_rx_irq = 1'b0, serial_tx_irq = 1'b0;
    reg          net_irq_primary = 1'b0, net_irq_secondary = 1'b0;
    reg  [31:0]  sys_rd_data = 32'h0, rd, ea = 32'h0, ew = 32'h0;
    reg  [3:0]   src;
    reg  [2:0]   vec_seen;
    integer      fail_count = 0, num_checks = 0, cycles = 0, dly = 2, i;
    logic [31:0] rd_q[$];
    wire         cpu_as_n, cpu_ds_n, cpu_ready_n, bus_data_oe_n, sys_req;
    wire         cpu_bus_isolate, cpu_bus_direction, sys_write;
    wire         col_strobe_3, col_strobe_2, col_strobe_1, col_strobe_0;
    wire         vector_addr_bit2, vector_addr_bit1, vector_addr_bit0;
    wire         cpu_irq_request;
    wire [1:0]   cpu_cycle_type;
    wire [31:0]  bus_addr_data_in, bus_data_out, sys_addr, sys_wr_data;
    wire [3:0]   vram_col_strobe;
    wire [11:0]  opt_col_strobe;
    wire [3:0]   cas = {col_strobe_3, col_strobe_2,
                        col_strobe_1, col_strobe_0};

    cbg_glue dut (.clk_en(1'b1), .*);
    cbg_cpu_model cpu (.*);

    ////////////////////////////////////////////////////////////////////////
    task check(input [63:0] seen, input [63:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    function [2:0] vec_of(input [3:0] s);
        vec_of = s[`CBG_IRQ_NET_PRI] ? `CBG_VEC_NET_PRI :
                 s[`CBG_IRQ_NET_SEC] ? `CBG_VEC_NET_SEC :
                 s[`CBG_IRQ_SER_RX] ? `CBG_VEC_SER_RX :
                 s[`CBG_IRQ_SER_TX] ? `CBG_VEC_SER_TX : `CBG_VEC_NONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // run ceiling, and the vector captured while cycle-done stands
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cpu_ready_n === 1'b0)
            vec_seen <= {vector_addr_bit2, vector_addr_bit1,
                         vector_addr_bit0};
        if (cycles == 6000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end

    // system side: answers after a random stall, checks the access
    // strobes follow the request by one edge, so stall at least once
    always @(posedge sys_clk) begin
        if (sys_req && !sys_ack && dly > 0) begin
            dly <= dly - 1;
            sys_ack <= 1'b0;
        end else if (sys_req && !sys_ack) begin
            check(sys_write, ew_on);
            check({sys_addr, cas}, {ea, ~(4'h1 << ea[25:24])});
            if (ew_on)
                check(sys_wr_data, ew);
            else
                rd_q.push_back($urandom);
            sys_rd_data <= rd_q.size() ? rd_q[$] : 32'h0;
            sys_ack <= 1'b1;
            dly <= 1 + $urandom % 3;
        end else
            sys_ack <= 1'b0;
    end

    initial begin
        void'($urandom(87803));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (i = 0; i < 13; i = i + 1) begin
            ea = $urandom;
            ew = $urandom;
            ew_on = i[0];
            cpu.run_cycle(i == 12 ? `CBG_CYC_NONE : ew_on ? `CBG_CYC_WRITE :
                          `CBG_CYC_READ, ea, ew, $urandom % 3, rd, ok);
            check(ok, i < 12);
            if (!ew_on && i < 12) begin
                check(rd, rd_q.pop_front());
                check(vec_seen, 3'h0);
            end
        end
        for (i = 0; i < 7; i = i + 1) begin
            src = i < 4 ? 4'h1 << i : (i == 4 ? 4'h0 : 4'($urandom));
            {net_irq_secondary, net_irq_primary, serial_tx_irq,
             serial_rx_irq} <= src;
            repeat (8) @(posedge sys_clk);
            check(cpu_irq_request, |src);
            cpu.run_cycle(`CBG_CYC_IACK, 32'h0, 32'h0, i % 2, rd, ok);
            check(rd, {29'h0, vec_of(src)});
            check(vec_seen, vec_of(src));
        end
        complete_run;
    end
endmodule // testbench
